// ### verilog/tfsa_defines.svh
`ifndef TFSA_DEFINES_SVH
`define TFSA_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TFSA_ADDR_CFG1        8'h01
`define TFSA_ADDR_MASK_TEMP   8'h08
`define TFSA_ADDR_MASK_OT     8'h09
`define TFSA_ADDR_MASK_FAN    8'h0A
`define TFSA_ADDR_STAT_TEMP   8'h4F
`define TFSA_ADDR_STAT_OT     8'h50
`define TFSA_ADDR_STAT_FAN    8'h51

// ----------------------------------------
// reset values
// ----------------------------------------
`define TFSA_CFG1_RST         8'h00
`define TFSA_MASK_RST         8'h00
`define TFSA_RDATA_RST        8'h00

// ----------------------------------------
// implemented bits per register
// ----------------------------------------
`define TFSA_MASK_TEMP_BITS   8'hFF
`define TFSA_MASK_OT_BITS     8'h1C
`define TFSA_MASK_FAN_BITS    8'hE0

// ----------------------------------------
// field positions and counts
// ----------------------------------------
`define TFSA_CFG1_ALERT_MODE  3
`define TFSA_OT_PIN_LEVEL_BIT 2
`define TFSA_FAN_ALERT_BIT    0
`define TFSA_NUM_CHAN         3
`define TFSA_NUM_STAT         3

`endif

// ### verilog/tfsa_pkg.sv
package tfsa_pkg;

    // ----------------------------------------
    // alert output modes
    // ----------------------------------------
    typedef enum logic {
        TFSA_ALERT_LATCHED,
        TFSA_ALERT_COMP
    } tfsa_mode_t;

    // ----------------------------------------
    // state of one sticky status register
    // ----------------------------------------
    typedef struct packed {
        logic [7:0] status;
    } tfsa_sticky_t;

    // ----------------------------------------
    // state of the alert controller
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
        logic [2:0] crit;
        logic [7:0] mask_temp;
        logic [7:0] mask_ot;
        logic [7:0] mask_fan;
        logic [7:0] cfg1;
        logic [7:0] rdata;
        logic       alert;
        logic       alert_o;
    } tfsa_main_t;

endpackage

// ### verilog/tfsa_sticky_bank.sv
`timescale 1ns/1ps
`include "tfsa_defines.svh"

module tfsa_sticky_bank #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic             rd_clr,
    input  wire logic             ara_clr,
    output      logic [WIDTH-1:0] status
);
    import tfsa_pkg::*;

    tfsa_sticky_t st_r;
    tfsa_sticky_t st_nxt;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (ce) begin
            if (rd_clr || ara_clr) begin
                st_nxt.status = '0;
            end
            st_nxt.status = st_nxt.status | cond;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign status = st_r.status[WIDTH-1:0];

endmodule

// ### verilog/tfsa_alert_ctrl.sv
`timescale 1ns/1ps
`include "tfsa_defines.svh"

module tfsa_alert_ctrl (
    input  wire logic            CLOCK,
    input  wire logic            RST_N,
    input  wire logic            CE,
    input  wire logic [7:0]      REG_ADDR,
    input  wire logic            REG_WR,
    input  wire logic            REG_RD,
    input  wire logic [7:0]      REG_WDATA,
    output      logic [7:0]      REG_RDATA,
    input  wire logic            ARA_DONE,
    input  wire logic [2:0]      MEAS_DONE,
    input  wire logic [2:0][7:0] TEMP_VALUE,
    input  wire logic [2:0][7:0] HIGH_LIMIT,
    input  wire logic [2:0][7:0] LOW_LIMIT,
    input  wire logic [2:0][7:0] CRIT_LIMIT,
    input  wire logic [1:0]      DIODE_FAULT,
    input  wire logic            OVERTEMP_PCT_OVER,
    input  wire logic            OVERTEMP_DRIVEN,
    input  wire logic            OVERTEMP_PIN_LEVEL,
    input  wire logic            FAN1_STALL,
    input  wire logic            COOLER_ALARM_SPEED,
    input  wire logic            FAN2_STALL,
    input  wire logic            ALERT_IN,
    output      logic            ALERT_O,
    output      logic            ALERT_OE,
    output      tfsa_pkg::tfsa_mode_t ALERT_MODE
);
    import tfsa_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic above_high(input logic [7:0] v,
                                        input logic [7:0] lim);
        above_high = (v >= lim);
    endfunction

    function automatic logic below_low(input logic [7:0] v,
                                       input logic [7:0] lim);
        below_low = (v < lim);
    endfunction

    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off);
        addr_hit = (a == off);
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    tfsa_main_t st_r;
    tfsa_main_t st_nxt;

    logic [2:0][7:0] cond;
    logic [2:0][7:0] status;
    logic [2:0][7:0] stat_off;
    logic [2:0]      rd_clr;
    logic            ara_clr;
    logic [7:0]      pend_temp;
    logic [7:0]      pend_ot;
    logic [7:0]      pend_fan;
    logic [7:0]      live_temp;
    logic [7:0]      live_ot;
    logic [7:0]      live_fan;
    logic [7:0]      comp_ot_mask;
    logic            any_pend;
    logic            any_live;
    tfsa_mode_t      mode;

    assign stat_off[0] = `TFSA_ADDR_STAT_TEMP;
    assign stat_off[1] = `TFSA_ADDR_STAT_OT;
    assign stat_off[2] = `TFSA_ADDR_STAT_FAN;

    // ----------------------------------------
    // live out-of-limit conditions
    // ----------------------------------------
    // first status bit order
    assign cond[0] = {st_r.hi[0], st_r.lo[0],
                      st_r.hi[1], st_r.lo[1], DIODE_FAULT[0],
                      st_r.hi[2], st_r.lo[2], DIODE_FAULT[1]};

    assign cond[1] = {st_r.crit[0], st_r.crit[1], st_r.crit[2],
                      OVERTEMP_PCT_OVER,
                      (|st_r.crit) & OVERTEMP_DRIVEN,
                      OVERTEMP_PIN_LEVEL,
                      2'h0};

    assign cond[2] = {FAN1_STALL, COOLER_ALARM_SPEED, FAN2_STALL,
                      5'h00};

    // ----------------------------------------
    // sticky status registers
    // ----------------------------------------
    assign ara_clr = ARA_DONE;

    genvar gi;
    generate
        for (gi = 0; gi < `TFSA_NUM_STAT; gi = gi + 1) begin : g_stat
            // clear on read of own register
            assign rd_clr[gi] = REG_RD & addr_hit(REG_ADDR,
                                                  stat_off[gi]);
            tfsa_sticky_bank #(
                .WIDTH (8)
            ) u_bank (
                .clk     (CLOCK),
                .rst_n   (RST_N),
                .ce      (CE),
                .cond    (cond[gi]),
                .rd_clr  (rd_clr[gi]),
                .ara_clr (ara_clr),
                .status  (status[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // alert sources
    // ----------------------------------------
    // mode from config1 bit 3
    assign mode = st_r.cfg1[`TFSA_CFG1_ALERT_MODE] ?
                  TFSA_ALERT_COMP : TFSA_ALERT_LATCHED;

    assign pend_temp = status[0] & ~st_r.mask_temp;
    assign pend_ot   = status[1] & ~st_r.mask_ot;
    assign pend_fan  = status[2] & ~st_r.mask_fan &
                       `TFSA_MASK_FAN_BITS;

    assign comp_ot_mask = st_r.mask_ot |
                          (8'h01 << `TFSA_OT_PIN_LEVEL_BIT);

    assign live_temp = cond[0] & ~st_r.mask_temp;
    assign live_ot   = cond[1] & ~comp_ot_mask;
    assign live_fan  = cond[2] & ~st_r.mask_fan &
                       `TFSA_MASK_FAN_BITS;

    assign any_pend = |{pend_temp, pend_ot, pend_fan};
    assign any_live = |{live_temp, live_ot, live_fan};

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.alert_o = 1'b0;
        if (CE) begin
            // ----------------------------------------
            // limit comparisons
            // ----------------------------------------
            // limit comparisons per channel
            for (int c = 0; c < `TFSA_NUM_CHAN; c++) begin
                if (MEAS_DONE[c]) begin
                    st_nxt.hi[c]   = above_high(TEMP_VALUE[c],
                                                HIGH_LIMIT[c]);
                    st_nxt.lo[c]   = below_low(TEMP_VALUE[c],
                                               LOW_LIMIT[c]);
                    st_nxt.crit[c] = above_high(TEMP_VALUE[c],
                                                CRIT_LIMIT[c]);
                end
            end

            // ----------------------------------------
            // register writes
            // ----------------------------------------
            // status registers are read-only
            if (REG_WR) begin
                if (addr_hit(REG_ADDR, `TFSA_ADDR_CFG1)) begin
                    st_nxt.cfg1 = REG_WDATA;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_MASK_TEMP)) begin
                    st_nxt.mask_temp = REG_WDATA &
                                       `TFSA_MASK_TEMP_BITS;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_MASK_OT)) begin
                    st_nxt.mask_ot = REG_WDATA & `TFSA_MASK_OT_BITS;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_MASK_FAN)) begin
                    st_nxt.mask_fan = REG_WDATA & `TFSA_MASK_FAN_BITS;
                end
            end

            // ----------------------------------------
            // register reads
            // ----------------------------------------
            // unmapped addresses read zero
            if (REG_RD) begin
                st_nxt.rdata = `TFSA_RDATA_RST;
                if (addr_hit(REG_ADDR, `TFSA_ADDR_CFG1)) begin
                    st_nxt.rdata = st_r.cfg1;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_MASK_TEMP)) begin
                    st_nxt.rdata = st_r.mask_temp;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_MASK_OT)) begin
                    st_nxt.rdata = st_r.mask_ot;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_MASK_FAN)) begin
                    st_nxt.rdata = st_r.mask_fan;
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_STAT_TEMP)) begin
                    st_nxt.rdata = status[0];
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_STAT_OT)) begin
                    st_nxt.rdata = status[1];
                end
                if (addr_hit(REG_ADDR, `TFSA_ADDR_STAT_FAN)) begin
                    st_nxt.rdata = status[2];
                    st_nxt.rdata[`TFSA_FAN_ALERT_BIT] = st_r.alert;
                end
            end

            // ----------------------------------------
            // alert update
            // ----------------------------------------
            // assert on unmasked source; comparator mode also ignores the OT pin-level bit
            unique case (mode)
                TFSA_ALERT_LATCHED: st_nxt.alert = any_pend;
                TFSA_ALERT_COMP:    st_nxt.alert = any_live;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            st_r.hi        <= 3'h0;
            st_r.lo        <= 3'h0;
            st_r.crit      <= 3'h0;
            st_r.mask_temp <= `TFSA_MASK_RST;
            st_r.mask_ot   <= `TFSA_MASK_RST;
            st_r.mask_fan  <= `TFSA_MASK_RST;
            st_r.cfg1      <= `TFSA_CFG1_RST;
            st_r.rdata     <= `TFSA_RDATA_RST;
            st_r.alert     <= 1'b0;
            st_r.alert_o   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // mode register
    // ----------------------------------------
    logic mode_r;

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            mode_r <= 1'b0;
        end else if (CE) begin
            mode_r <= st_nxt.cfg1[`TFSA_CFG1_ALERT_MODE];
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign REG_RDATA  = st_r.rdata;
    assign ALERT_O    = st_r.alert_o;
    assign ALERT_OE   = st_r.alert;
    assign ALERT_MODE = mode_r ? TFSA_ALERT_COMP : TFSA_ALERT_LATCHED;

endmodule

// ### verif/tfsa_alert_ctrl_sva.sv
`timescale 1ns/1ps
module tfsa_alert_ctrl_sva (
    input wire logic       CLOCK,
    input wire logic       RST_N,
    input wire logic       CE,
    input wire logic [7:0] REG_ADDR,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic       ARA_DONE,
    input wire logic       FAN1_STALL,
    input wire logic       ALERT_O,
    input wire logic       ALERT_OE,
    input wire tfsa_pkg::tfsa_mode_t ALERT_MODE
);
    import tfsa_pkg::*;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    chk_mode_follow: assert property (
        CE && REG_WR && REG_ADDR == 8'h01 && REG_WDATA[3]
        |=> ##[0:1] ALERT_MODE == TFSA_ALERT_COMP)
        else $error("alert mode did not follow config write");
    chk_unmapped_zero: assert property (
        CE && REG_RD && !(REG_ADDR inside {8'h01, 8'h08, 8'h09,
        8'h0A, 8'h4F, 8'h50, 8'h51}) |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_hold: assert property (
        CE && !REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without read");
    chk_alert_bit: assert property (
        CE && REG_RD && REG_ADDR == 8'h51
        |=> REG_RDATA[0] == $past(ALERT_OE))
        else $error("alert flag does not match line");
    chk_fan1_status: assert property (
        CE && REG_RD && REG_ADDR == 8'h51 && FAN1_STALL
        && $past(FAN1_STALL) && $past(CE) && $past(RST_N)
        |=> REG_RDATA[7])
        else $error("fan1 stall not reported");
    chk_latch_hold: assert property (
        (ALERT_MODE == TFSA_ALERT_LATCHED && CE && !REG_RD
        && !REG_WR && !ARA_DONE) ##1 (ALERT_OE && CE
        && ALERT_MODE == TFSA_ALERT_LATCHED) |=> ALERT_OE)
        else $error("latched alert dropped without service");
    chk_ce_freeze: assert property (
        !CE |=> $stable(REG_RDATA) && $stable(ALERT_OE)
        && $stable(ALERT_MODE))
        else $error("state moved with enable low");
    chk_odrain_low: assert property (
        ALERT_O == 1'b0)
        else $error("alert data not low");
endmodule

bind tfsa_alert_ctrl tfsa_alert_ctrl_sva i_sva (.CLOCK, .RST_N, .CE,
    .REG_ADDR, .REG_WR, .REG_RD, .REG_WDATA, .REG_RDATA, .ARA_DONE,
    .FAN1_STALL, .ALERT_O, .ALERT_OE, .ALERT_MODE);

// ### verif/tfsa_host_model.sv
`timescale 1ns/1ps
module tfsa_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    output      logic [7:0] addr,
    output      logic       wr,
    output      logic       rd,
    output      logic [7:0] wdata,
    output      logic       ara
);
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
        ara = 1'b0;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic ara_cycle();
        @(posedge clk);
        ara <= 1'b1;
        @(posedge clk);
        ara <= 1'b0;
    endtask
endmodule

// ### verif/thermal_fan_status_alert_tb_top.sv
`timescale 1ns/1ps
module thermal_fan_status_alert_tb_top;
    import tfsa_pkg::*;
    logic            clock = 1'b0;
    logic            rst_n, ce, wr, rd, ara, a_o, a_oe, alert_in;
    logic            pct, drv, pin, f1, fa, f2;
    logic [7:0]      addr, wdata, rdata;
    logic [2:0]      meas;
    logic [1:0]      diode;
    logic [2:0][7:0] temp, hlim, llim, clim;
    tfsa_mode_t      mode;
    int              miscompares = 0;
    int              n_compared = 0;
    logic [7:0]      regs [7] = '{8'h01, 8'h08, 8'h09, 8'h0A, 8'h4F,
                                  8'h50, 8'h51};
    assign alert_in = a_oe ? a_o : 1'b1;
    always #5 clock = ~clock;
    tfsa_alert_ctrl i_tfsa_alert_ctrl (.CLOCK(clock), .RST_N(rst_n),
        .CE(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .ARA_DONE(ara),
        .MEAS_DONE(meas), .TEMP_VALUE(temp), .HIGH_LIMIT(hlim),
        .LOW_LIMIT(llim), .CRIT_LIMIT(clim), .DIODE_FAULT(diode),
        .OVERTEMP_PCT_OVER(pct), .OVERTEMP_DRIVEN(drv),
        .OVERTEMP_PIN_LEVEL(pin), .FAN1_STALL(f1),
        .COOLER_ALARM_SPEED(fa), .FAN2_STALL(f2), .ALERT_IN(alert_in),
        .ALERT_O(a_o), .ALERT_OE(a_oe), .ALERT_MODE(mode));
    tfsa_host_model i_tfsa_host_model (.clk(clock), .rdata(rdata),
        .addr(addr), .wr(wr), .rd(rd), .wdata(wdata), .ara(ara));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        i_tfsa_host_model.rd_reg(a, v);
        chk($sformatf("reg %h", a), e, v);
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        i_tfsa_host_model.wr_reg(a, d);
    endtask
    task automatic oe(input logic e);
        #1 chk("alert_oe", {7'h00, e}, {7'h00, a_oe});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic meas_all(input logic [7:0] t0, t1, t2);
        @(posedge clock);
        temp <= {t2, t1, t0};
        meas <= 3'h7;
        @(posedge clock);
        meas <= 3'h0;
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        cyc(2000);
        miscompares++;
        tally_and_finish();
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rst_n, meas, diode, pct, drv, pin, f1, fa, f2} = '0;
        ce = 1'b1;
        temp = {3{8'h30}};
        hlim = {3{8'h50}};
        llim = {3{8'h10}};
        clim = {3{8'h60}};
        cyc(3);
        rst_n <= 1'b1;
        foreach (regs[i]) rdc(regs[i], 8'h00);
        wrr(8'h08, 8'hFF);
        rdc(8'h08, 8'hFF);
        wrr(8'h09, 8'hFF);
        rdc(8'h09, 8'h1C);
        wrr(8'h0A, 8'hFF);
        rdc(8'h0A, 8'hE0);
        wrr(8'h20, 8'hFF);
        rdc(8'h20, 8'h00);
        cyc(1);
        diode <= 2'b01;
        cyc(3);
        oe(1'b0);
        rdc(8'h4F, 8'h08);
        cyc(1);
        diode <= 2'b00;
        rdc(8'h4F, 8'h08);
        rdc(8'h4F, 8'h00);
        for (int i = 0; i < 3; i++) wrr(8'h08 + 8'(i), 8'h00);
        meas_all(8'h50, 8'h10, 8'h0F);
        cyc(3);
        oe(1'b1);
        meas_all(8'h30, 8'h30, 8'h30);
        cyc(3);
        oe(1'b1);
        rdc(8'h4F, 8'h82);
        cyc(2);
        oe(1'b0);
        rdc(8'h4F, 8'h00);
        cyc(1);
        {f1, fa, f2} <= 3'b111;
        cyc(3);
        rdc(8'h51, 8'hE1);
        cyc(1);
        {f1, fa} <= 2'b00;
        i_tfsa_host_model.ara_cycle();
        cyc(2);
        oe(1'b1);
        rdc(8'h51, 8'h21);
        cyc(1);
        f2 <= 1'b0;
        i_tfsa_host_model.ara_cycle();
        cyc(2);
        oe(1'b0);
        cyc(1);
        {drv, pct, pin} <= 3'b111;
        meas_all(8'h30, 8'h60, 8'h30);
        cyc(3);
        rdc(8'h50, 8'h5C);
        rdc(8'h4F, 8'h20);
        cyc(1);
        {drv, pct, pin} <= 3'b000;
        meas_all(8'h30, 8'h30, 8'h30);
        cyc(3);
        rdc(8'h50, 8'h5C);
        rdc(8'h50, 8'h00);
        i_tfsa_host_model.ara_cycle();
        cyc(1);
        ce <= 1'b0;
        cyc(3);
        ce <= 1'b1;
        wrr(8'h01, 8'h08);
        rdc(8'h01, 8'h08);
        chk("alert_mode", 8'h01, {7'h00, mode});
        cyc(1);
        pin <= 1'b1;
        cyc(3);
        oe(1'b0);
        cyc(1);
        f2 <= 1'b1;
        cyc(3);
        oe(1'b1);
        cyc(1);
        f2 <= 1'b0;
        cyc(3);
        oe(1'b0);
        tally_and_finish();
    end
endmodule
